// ==== verilog/rtc_pkg.sv ====
/*
  Constants for the receive timing and channel-check controller:
  register indices, field positions, reset values, codes, timing.
  Assumes a 20 MHz mclk and 32-bit APB with word-indexed registers.
*/
package rtc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_CLEAR_THRESHOLD = 10'h105;
  localparam logic [9:0] IDX_CHANNEL_CHECK = 10'h106;
  localparam logic [9:0] IDX_RX_BUFFER_BEHAVIOR = 10'h107;
  localparam logic [9:0] IDX_PACKET_OPTIONS = 10'h108;
  localparam logic [9:0] IDX_RX_TURNON_DELAY = 10'h109;
  localparam logic [9:0] IDX_EXTENDED_MAC_DELAY = 10'h10b;
  localparam logic [9:0] IDX_RADIO_MODE_SELECT = 10'h13e;
  localparam logic [9:0] IDX_QUALITY_READBACK = 10'h30d;
  localparam logic [9:0] IDX_SIGNAL_AVG_CONFIG = 10'h3b9;
  localparam logic [9:0] IDX_COMMAND = 10'h001;
  localparam logic [9:0] IDX_STATUS = 10'h002;
  localparam logic [9:0] IDX_TX_TURNON_DELAY = 10'h003;
  localparam logic [9:0] IDX_SIGNAL_READBACK = 10'h004;

  // Field positions
  localparam int AUTO_CHECK_BIT = 1;
  localparam int REPEAT_CHECK_BIT = 2;
  localparam int RAW_CHECKSUM_BIT = 0;
  localparam int FILTER_EN_BIT = 1;
  localparam int AUTO_ACK_EN_BIT = 2;
  localparam int AUTO_LISTEN_BIT = 3;
  localparam int STAT_IDLE_BIT = 0;
  localparam int STAT_RX_BIT = 1;
  localparam int STAT_CLEAR_BIT = 2;
  localparam int STAT_CHECK_BIT = 3;

  // Reset values
  localparam logic [7:0] RST_CLEAR_THRESHOLD = 8'h00;
  localparam logic [7:0] RST_CHANNEL_CHECK = 8'h00;
  localparam logic [7:0] RST_RX_BUFFER = 8'h00;
  localparam logic [7:0] RST_PACKET_OPTIONS = 8'h00;
  localparam logic [7:0] RST_RX_TURNON = 8'h00;
  localparam logic [7:0] RST_EXT_DELAY = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_AVG_CONFIG = 8'h02;
  localparam logic [7:0] RST_TX_TURNON = 8'hc0;

  // Operating modes, buffer modes, commands, frame types
  localparam logic [7:0] MODE_PACKET = 8'h00;
  localparam logic [7:0] MODE_SERIAL_PORT = 8'h02;
  localparam logic [1:0] BUF_TO_IDLE = 2'h0;
  localparam logic [1:0] BUF_NO_RECEPTION = 2'h2;
  localparam logic [7:0] CMD_RECEIVE = 8'h01;
  localparam logic [7:0] CMD_CHANNEL_CHECK = 8'h02;
  localparam logic [7:0] CMD_IDLE_READY = 8'h03;
  localparam logic [2:0] FTYPE_BEACON = 3'h0;
  localparam logic [2:0] FTYPE_ACK = 3'h2;

  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int US_NS = 1000;
  localparam int CYC_PER_US = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EXT_DELAY_UNIT_US = 4;
  localparam int AVG_BASE_US = 16;
  localparam int AVG_BASE_SHIFT = 4;
  localparam int DELAY_W = 11;
endpackage

// ==== verilog/rtc_delay_timer.sv ====
/*
  Microsecond countdown used for the MAC delays.
  Assumes a one-cycle us_tick from the parent; a zero load elapses at once.
*/
`timescale 1ns/10ps
module rtc_delay_timer #(
  parameter int CW = 11
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Control
  input wire logic us_tick,
  input wire logic load,
  input wire logic [CW-1:0] count_us,
  // Status
  output logic elapsed
);
  logic [CW-1:0] count_r;
  logic run_r;
  logic elapsed_r;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      count_r <= '0;
      run_r <= 1'b0;
      elapsed_r <= 1'b0;
    end else if (load) begin
      count_r <= count_us;
      run_r <= (count_us != '0);
      elapsed_r <= (count_us == '0);
    end else if (run_r && us_tick) begin
      count_r <= count_r - 1'b1;
      if (count_r == {{(CW-1){1'b0}}, 1'b1}) begin
        run_r <= 1'b0;
        elapsed_r <= 1'b1;
      end
    end
  end

  assign elapsed = elapsed_r;
endmodule

// ==== verilog/rtc_avg_window.sv ====
/*
  Signal-strength averaging window of 16 << sel microseconds.
  Assumes one sample per us_tick; a start restarts the window.
*/
`timescale 1ns/10ps
module rtc_avg_window (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Control
  input wire logic us_tick,
  input wire logic start,
  input wire logic stop,
  input wire logic [1:0] sel,
  input wire logic [7:0] rssi,
  // Result
  output logic busy,
  output logic done,
  output logic [7:0] average
);
  logic [14:0] acc_r;
  logic [7:0] cnt_r;
  logic busy_r;
  logic done_r;
  logic [7:0] avg_r;
  logic [14:0] sum;
  logic [7:0] target;

  assign sum = acc_r + {7'h00, rssi};
  assign target = 8'(rtc_pkg::AVG_BASE_US << sel);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      acc_r <= '0;
      cnt_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      avg_r <= '0;
    end else begin
      done_r <= 1'b0;
      if (start) begin
        acc_r <= '0;
        cnt_r <= '0;
        busy_r <= 1'b1;
      end else if (stop) begin
        busy_r <= 1'b0;
      end else if (busy_r && us_tick) begin
        acc_r <= sum;
        cnt_r <= cnt_r + 8'h01;
        if (cnt_r + 8'h01 == target) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
          avg_r <= 8'(sum >> (rtc_pkg::AVG_BASE_SHIFT + int'(sel)));
        end
      end
    end
  end

  assign busy = busy_r;
  assign done = done_r;
  assign average = avg_r;
endmodule

// ==== verilog/rtc_ctrl.sv ====
/*
  Receive timing, channel check and acknowledge control, with APB registers.
  Assumes radio datapath status arrives synchronous to mclk as pulses.
*/
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
module rtc_ctrl (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Calibration
  output logic synth_cal_req,
  output logic rx_cal_req,
  input wire logic synth_cal_done,
  input wire logic rx_cal_done,
  // Receive datapath
  output logic rx_enable,
  input wire logic [7:0] rssi,
  input wire logic sfd_detect,
  input wire logic frame_end,
  input wire logic checksum_ok,
  input wire logic addr_match,
  input wire logic [2:0] frame_type,
  input wire logic ack_request,
  input wire logic [7:0] frame_seq,
  input wire logic [7:0] frame_quality,
  output logic quality_wr,
  output logic [7:0] quality_data,
  // Transmit side
  input wire logic tx_done,
  output logic ack_build,
  output logic [7:0] ack_seq,
  output logic ack_tx_req,
  // Events
  output logic evt_check_done,
  output logic evt_frame_start,
  output logic evt_frame_rcvd
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_CAL_SYN, ST_CAL_RX, ST_RX_DLY, ST_RX,
    ST_CCA_DLY, ST_CCA, ST_ACK_DLY, ST_ACK_TX
  } rtc_state_e;

  rtc_state_e state_r;
  logic [7:0] clear_threshold_r;
  logic [7:0] channel_check_r;
  logic [7:0] rx_buffer_r;
  logic [7:0] packet_options_r;
  logic [7:0] rx_turnon_r;
  logic [7:0] ext_delay_r;
  logic [7:0] mode_r;
  logic [7:0] quality_r;
  logic [7:0] avg_config_r;
  logic [7:0] tx_turnon_r;
  logic [7:0] signal_rb_r;
  logic clear_r;
  logic check_done_r;
  logic listen_r;
  logic [4:0] pre_r;
  logic [31:0] prdata_r;
  logic us_tick;
  logic wr_en;
  logic rd_setup;
  logic [9:0] idx;
  logic mapped;
  logic [31:0] rd_mux;
  logic cmd_valid;
  logic [7:0] cmd_code;
  logic timer_load;
  logic [rtc_pkg::DELAY_W-1:0] timer_count;
  logic [rtc_pkg::DELAY_W-1:0] rx_delay_us;
  logic [rtc_pkg::DELAY_W-1:0] tx_delay_us;
  logic timer_elapsed;
  logic avg_start;
  logic avg_stop;
  logic avg_busy;
  logic avg_done;
  logic [7:0] avg_value;
  logic packet_mode;
  logic frame_ok;
  logic want_ack;
  logic take_frame;
  logic to_rx_dly;
  logic to_ack_dly;

  // APB decode, zero wait states
  assign idx = paddr[11:2];
  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign cmd_valid = wr_en && (idx == rtc_pkg::IDX_COMMAND);
  assign cmd_code = pwdata[7:0];

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (idx)
      rtc_pkg::IDX_CLEAR_THRESHOLD: rd_mux[7:0] = clear_threshold_r;
      rtc_pkg::IDX_CHANNEL_CHECK: rd_mux[7:0] = channel_check_r;
      rtc_pkg::IDX_RX_BUFFER_BEHAVIOR: rd_mux[7:0] = rx_buffer_r;
      rtc_pkg::IDX_PACKET_OPTIONS: rd_mux[7:0] = packet_options_r;
      rtc_pkg::IDX_RX_TURNON_DELAY: rd_mux[7:0] = rx_turnon_r;
      rtc_pkg::IDX_EXTENDED_MAC_DELAY: rd_mux[7:0] = ext_delay_r;
      rtc_pkg::IDX_RADIO_MODE_SELECT: rd_mux[7:0] = mode_r;
      rtc_pkg::IDX_QUALITY_READBACK: rd_mux[7:0] = quality_r;
      rtc_pkg::IDX_SIGNAL_AVG_CONFIG: rd_mux[7:0] = avg_config_r;
      rtc_pkg::IDX_TX_TURNON_DELAY: rd_mux[7:0] = tx_turnon_r;
      rtc_pkg::IDX_SIGNAL_READBACK: rd_mux[7:0] = signal_rb_r;
      rtc_pkg::IDX_COMMAND: rd_mux = 32'h0000_0000;
      rtc_pkg::IDX_STATUS: begin
        rd_mux[rtc_pkg::STAT_IDLE_BIT] = (state_r == ST_IDLE);
        rd_mux[rtc_pkg::STAT_RX_BIT] = (state_r == ST_RX);
        rd_mux[rtc_pkg::STAT_CLEAR_BIT] = clear_r;
        rd_mux[rtc_pkg::STAT_CHECK_BIT] = avg_busy;
      end
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prdata_r <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_r <= rd_mux;
    end
  end

  assign prdata = prdata_r;

  // Software-written configuration
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      clear_threshold_r <= rtc_pkg::RST_CLEAR_THRESHOLD;
      channel_check_r <= rtc_pkg::RST_CHANNEL_CHECK;
      rx_buffer_r <= rtc_pkg::RST_RX_BUFFER;
      packet_options_r <= rtc_pkg::RST_PACKET_OPTIONS;
      rx_turnon_r <= rtc_pkg::RST_RX_TURNON;
      ext_delay_r <= rtc_pkg::RST_EXT_DELAY;
      mode_r <= rtc_pkg::RST_MODE;
      avg_config_r <= rtc_pkg::RST_AVG_CONFIG;
      tx_turnon_r <= rtc_pkg::RST_TX_TURNON;
    end else if (wr_en) begin
      unique case (idx)
        rtc_pkg::IDX_CLEAR_THRESHOLD: clear_threshold_r <= pwdata[7:0];
        rtc_pkg::IDX_CHANNEL_CHECK: channel_check_r <= pwdata[7:0];
        rtc_pkg::IDX_RX_BUFFER_BEHAVIOR: rx_buffer_r <= pwdata[7:0];
        rtc_pkg::IDX_PACKET_OPTIONS: packet_options_r <= pwdata[7:0];
        rtc_pkg::IDX_RX_TURNON_DELAY: rx_turnon_r <= pwdata[7:0];
        rtc_pkg::IDX_EXTENDED_MAC_DELAY: ext_delay_r <= pwdata[7:0];
        rtc_pkg::IDX_RADIO_MODE_SELECT: mode_r <= pwdata[7:0];
        rtc_pkg::IDX_SIGNAL_AVG_CONFIG: avg_config_r <= pwdata[7:0];
        rtc_pkg::IDX_TX_TURNON_DELAY: tx_turnon_r <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Microsecond tick
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pre_r <= '0;
    end else if (pre_r == 5'(rtc_pkg::CYC_PER_US - 1)) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_r + 5'h01;
    end
  end

  assign us_tick = (pre_r == 5'(rtc_pkg::CYC_PER_US - 1));

  // Delays in microseconds
  assign rx_delay_us = rtc_pkg::DELAY_W'(rx_turnon_r)
    + rtc_pkg::DELAY_W'(ext_delay_r) * rtc_pkg::DELAY_W'(rtc_pkg::EXT_DELAY_UNIT_US);
  assign tx_delay_us = rtc_pkg::DELAY_W'(tx_turnon_r)
    + rtc_pkg::DELAY_W'(ext_delay_r) * rtc_pkg::DELAY_W'(rtc_pkg::EXT_DELAY_UNIT_US);

  // Frame acceptance
  assign packet_mode = (mode_r == rtc_pkg::MODE_PACKET);
  assign frame_ok = (checksum_ok || packet_options_r[rtc_pkg::RAW_CHECKSUM_BIT])
    && (!packet_options_r[rtc_pkg::FILTER_EN_BIT] || addr_match);
  assign take_frame = (state_r == ST_RX) && frame_end && packet_mode
    && (rx_buffer_r[1:0] != rtc_pkg::BUF_NO_RECEPTION) && frame_ok;
  assign want_ack = packet_options_r[rtc_pkg::FILTER_EN_BIT]
    && packet_options_r[rtc_pkg::AUTO_ACK_EN_BIT]
    && frame_type != rtc_pkg::FTYPE_BEACON
    && frame_type != rtc_pkg::FTYPE_ACK && ack_request;

  assign to_rx_dly = (state_r == ST_CAL_RX) && rx_cal_done;
  assign to_ack_dly = take_frame && want_ack;

  // One delay timer, loaded at each delay start
  always_comb begin
    timer_load = 1'b0;
    timer_count = rx_delay_us;
    if (cmd_valid && (cmd_code == rtc_pkg::CMD_RECEIVE
        || cmd_code == rtc_pkg::CMD_CHANNEL_CHECK)) begin
      timer_load = 1'b1;
    end else if (state_r == ST_IDLE && tx_done && rx_buffer_r[rtc_pkg::AUTO_LISTEN_BIT]
        && packet_mode) begin
      timer_load = 1'b1;
    end else if (to_ack_dly) begin
      timer_load = 1'b1;
      timer_count = tx_delay_us;
    end
  end

  rtc_delay_timer #(
    .CW(rtc_pkg::DELAY_W)
  ) u_timer (
    .mclk(mclk),
    .rstn(rstn),
    .us_tick(us_tick),
    .load(timer_load),
    .count_us(timer_count),
    .elapsed(timer_elapsed)
  );

  // Window starts: on receive entry, after check delay, on repeat
  assign avg_start = (state_r == ST_RX_DLY && timer_elapsed
      && channel_check_r[rtc_pkg::AUTO_CHECK_BIT])
    || (state_r == ST_CCA_DLY && timer_elapsed)
    || (state_r == ST_CCA && check_done_r
      && channel_check_r[rtc_pkg::REPEAT_CHECK_BIT]);
  assign avg_stop = cmd_valid;

  rtc_avg_window u_avg (
    .mclk(mclk),
    .rstn(rstn),
    .us_tick(us_tick),
    .start(avg_start),
    .stop(avg_stop),
    .sel(avg_config_r[1:0]),
    .rssi(rssi),
    .busy(avg_busy),
    .done(avg_done),
    .average(avg_value)
  );

  // Readback, clear flag and done all move in the cycle after the window ends
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      signal_rb_r <= 8'h00;
      clear_r <= 1'b0;
      check_done_r <= 1'b0;
    end else begin
      check_done_r <= avg_done;
      if (avg_done) begin
        signal_rb_r <= avg_value;
        clear_r <= (avg_value < clear_threshold_r);
      end
    end
  end

  // Radio controller sequencing
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
      listen_r <= 1'b0;
    end else if (cmd_valid && cmd_code == rtc_pkg::CMD_IDLE_READY) begin
      state_r <= ST_IDLE;
      listen_r <= 1'b0;
    end else if (cmd_valid && cmd_code == rtc_pkg::CMD_RECEIVE) begin
      state_r <= ST_CAL_SYN;
      listen_r <= 1'b0;
    end else if (cmd_valid && cmd_code == rtc_pkg::CMD_CHANNEL_CHECK) begin
      state_r <= ST_CCA_DLY;
      listen_r <= 1'b0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (timer_load) begin
            state_r <= ST_RX_DLY;
            listen_r <= 1'b1;
          end
        end
        ST_CAL_SYN: begin
          if (synth_cal_done) begin
            state_r <= ST_CAL_RX;
          end
        end
        ST_CAL_RX: begin
          if (to_rx_dly) begin
            state_r <= ST_RX_DLY;
          end
        end
        ST_RX_DLY: begin
          if (timer_elapsed) begin
            state_r <= ST_RX;
          end
        end
        ST_RX: begin
          if (to_ack_dly) begin
            state_r <= ST_ACK_DLY;
          end else if (take_frame && (listen_r
              || rx_buffer_r[1:0] == rtc_pkg::BUF_TO_IDLE)) begin
            state_r <= ST_IDLE;
            listen_r <= 1'b0;
          end
        end
        ST_CCA_DLY: begin
          if (timer_elapsed) begin
            state_r <= ST_CCA;
          end
        end
        ST_CCA: begin
          if (check_done_r && !channel_check_r[rtc_pkg::REPEAT_CHECK_BIT]) begin
            state_r <= ST_IDLE;
          end
        end
        ST_ACK_DLY: begin
          if (timer_elapsed) begin
            state_r <= ST_ACK_TX;
          end
        end
        ST_ACK_TX: begin
          if (tx_done) begin
            state_r <= ST_IDLE;
            listen_r <= 1'b0;
          end
        end
      endcase
    end
  end

  // Frame events, quality store and acknowledge build
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      evt_frame_start <= 1'b0;
      evt_frame_rcvd <= 1'b0;
      quality_wr <= 1'b0;
      quality_data <= 8'h00;
      quality_r <= 8'h00;
      ack_build <= 1'b0;
      ack_seq <= 8'h00;
    end else begin
      evt_frame_start <= (state_r == ST_RX) && sfd_detect;
      evt_frame_rcvd <= take_frame;
      quality_wr <= take_frame && !packet_options_r[rtc_pkg::RAW_CHECKSUM_BIT];
      ack_build <= to_ack_dly;
      if (take_frame) begin
        quality_data <= frame_quality;
        quality_r <= frame_quality;
      end
      if (to_ack_dly) begin
        ack_seq <= frame_seq;
      end
    end
  end

  assign evt_check_done = check_done_r;
  assign synth_cal_req = (state_r == ST_CAL_SYN);
  assign rx_cal_req = (state_r == ST_CAL_RX);
  assign rx_enable = (state_r == ST_RX);
  assign ack_tx_req = (state_r == ST_ACK_TX);
endmodule

// ==== tb/rtc_chk.sv ====
/*
  Port checker for rtc_ctrl.
  Assumes one mclk domain; bound to the controller at the foot.
*/
`timescale 1ns/10ps
module rtc_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // Sequencing
  input wire logic synth_cal_req,
  input wire logic rx_cal_req,
  input wire logic rx_enable,
  input wire logic tx_done,
  input wire logic ack_tx_req,
  // Frames
  input wire logic sfd_detect,
  input wire logic frame_end,
  input wire logic addr_match,
  input wire logic ack_request,
  input wire logic [2:0] frame_type,
  input wire logic [7:0] frame_seq,
  input wire logic [7:0] frame_quality,
  input wire logic quality_wr,
  input wire logic [7:0] quality_data,
  input wire logic ack_build,
  input wire logic [7:0] ack_seq,
  // Events
  input wire logic evt_check_done,
  input wire logic evt_frame_start,
  input wire logic evt_frame_rcvd
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic idle_wr;
  assign idle_wr = psel && penable && pwrite && pready && paddr[11:2] == rtc_pkg::IDX_COMMAND
    && pwdata[7:0] == rtc_pkg::CMD_IDLE_READY;
  AST_CAL_ORDER: assert property ($rose(rx_cal_req) |-> $past(synth_cal_req))
    else $error("receive calibration without synthesizer calibration");
  AST_RX_EXCL: assert property (rx_enable |-> !synth_cal_req && !rx_cal_req)
    else $error("receiving while calibrating");
  AST_SFD_EVT: assert property (evt_frame_start |-> $past(sfd_detect))
    else $error("frame start event without delimiter");
  AST_SFD_SEEN: assert property (rx_enable && sfd_detect |=> evt_frame_start)
    else $error("delimiter while receiving raised no frame start event");
  AST_RCVD_CAUSE: assert property (evt_frame_rcvd |-> $past(frame_end))
    else $error("frame received event without frame end");
  AST_ACK_SEQ: assert property (ack_build |-> evt_frame_rcvd && ack_seq == $past(frame_seq))
    else $error("acknowledge sequence not copied");
  AST_ACK_COND: assert property (ack_build |-> $past(addr_match && ack_request
    && frame_type != rtc_pkg::FTYPE_BEACON && frame_type != rtc_pkg::FTYPE_ACK))
    else $error("acknowledge built for ineligible frame");
  AST_QUALITY: assert property (quality_wr |-> quality_data == $past(frame_quality))
    else $error("stored quality differs from measured");
  AST_DONE_GAP: assert property (evt_check_done |=> !evt_check_done [*8])
    else $error("check done repeated within a window");
  AST_ACK_HOLD: assert property (ack_tx_req && !tx_done && !(psel && pwrite) |=> ack_tx_req)
    else $error("acknowledge request dropped early");
  AST_IDLE_CMD: assert property (idle_wr |-> ##[1:3] !rx_enable && !rx_cal_req)
    else $error("idle command did not stop reception");
  COV_ACK: cover property (ack_build);
  COV_RX: cover property ($rose(rx_enable));
  COV_DONE: cover property (evt_check_done);
endmodule

bind rtc_ctrl rtc_chk u_chk (.*);

// ==== tb/rtc_radio_model.sv ====
/*
  Radio datapath stand-in: calibration answers, signal level, frames, send done.
  Assumes the bench calls its tasks just after a rising mclk edge.
*/
`timescale 1ns/10ps
module rtc_radio_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // From controller and bench
  input wire logic synth_cal_req,
  input wire logic rx_cal_req,
  input wire logic [7:0] rssi_lvl,
  // To controller
  output logic synth_cal_done,
  output logic rx_cal_done,
  output logic [7:0] rssi,
  output logic sfd_detect,
  output logic frame_end,
  output logic checksum_ok,
  output logic addr_match,
  output logic ack_request,
  output logic [2:0] frame_type,
  output logic [7:0] frame_seq,
  output logic [7:0] frame_quality,
  output logic tx_done
);
  assign rssi = rssi_lvl;
  initial begin
    {sfd_detect, frame_end, checksum_ok, addr_match, ack_request, tx_done} = 6'h0;
    {frame_type, frame_seq, frame_quality} = 19'h0;
  end
  // Calibration ends one cycle after it is asked for
  always @(posedge mclk) begin
    synth_cal_done <= synth_cal_req && rstn;
    rx_cal_done <= rx_cal_req && rstn;
  end
  task automatic send_frame(input logic [7:0] sq, input logic [2:0] ft, input logic ar,
      input logic [7:0] ql, input logic am);
    @(posedge mclk);
    sfd_detect <= 1'b1;
    @(posedge mclk);
    sfd_detect <= 1'b0;
    repeat (40) @(posedge mclk);
    frame_end <= 1'b1;
    {checksum_ok, addr_match, ack_request} <= {1'b1, am, ar};
    {frame_type, frame_seq, frame_quality} <= {ft, sq, ql};
    @(posedge mclk);
    // Released fields no longer show the frame
    frame_end <= 1'b0;
    {checksum_ok, addr_match, ack_request} <= ~{1'b1, am, ar};
    {frame_type, frame_seq, frame_quality} <= ~{ft, sq, ql};
  endtask
  task automatic send_done();
    @(posedge mclk);
    tx_done <= 1'b1;
    @(posedge mclk);
    tx_done <= 1'b0;
  endtask
endmodule

// ==== tb/tb.sv ====
/*
  Self-checking bench for rtc_ctrl over APB.
  Assumes the radio model answers calibration and sends frames on request.
*/
`timescale 1ns/10ps
module tb;
  logic mclk, rstn, psel, penable, pwrite, pready, pslverr, quality_wr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic synth_cal_req, rx_cal_req, synth_cal_done, rx_cal_done, rx_enable, tx_done;
  logic sfd_detect, frame_end, checksum_ok, addr_match, ack_request, ack_build, ack_tx_req;
  logic [2:0] frame_type;
  logic [7:0] rssi, rssi_lvl, frame_seq, frame_quality, quality_data, ack_seq;
  logic evt_check_done, evt_frame_start, evt_frame_rcvd, err;
  int n_mismatch, tests_run, c, i, n_sfd;
  rtc_ctrl dut (.*);
  rtc_radio_model model (.*);
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Frame-start events seen while receiving
  always @(posedge mclk) begin
    if (evt_frame_start === 1'b1) begin
      n_sfd++;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  task automatic near(input int got, input int exp);
    chk((got >= exp - 30 && got <= exp + 30) ? exp : got, exp);
  endtask
  task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask
  task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h0);
    chk(q, exp);
  endtask
  // Cycles until a watched output is high, or lim
  task automatic waitsig(input int s, input int lim);
    c = 0;
    do begin
      @(posedge mclk);
      c++;
    end while (c < lim && (s == 0 ? rx_enable : s == 1 ? evt_check_done :
      s == 2 ? ack_tx_req : evt_frame_rcvd) !== 1'b1);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge mclk);
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata} = 48'h0;
    rssi_lvl = 8'h10;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    rd(rtc_pkg::IDX_SIGNAL_AVG_CONFIG, 32'h2);
    rd(rtc_pkg::IDX_TX_TURNON_DELAY, 32'hc0);
    apb(1'b0, 10'h3ff, 8'h0);
    chk(q, 32'h0);
    chk({31'h0, err}, 32'h1);
    wr(rtc_pkg::IDX_CLEAR_THRESHOLD, 8'h40);
    wr(rtc_pkg::IDX_RX_TURNON_DELAY, 8'h03);
    wr(rtc_pkg::IDX_EXTENDED_MAC_DELAY, 8'h02);
    for (i = 0; i < 4; i++) begin
      rssi_lvl <= i[0] ? 8'h80 : 8'h10;
      wr(rtc_pkg::IDX_SIGNAL_AVG_CONFIG, i[7:0]);
      wr(rtc_pkg::IDX_COMMAND, rtc_pkg::CMD_CHANNEL_CHECK);
      waitsig(1, 5000);
      near(c, 220 + (320 << i));
      rd(rtc_pkg::IDX_STATUS, {29'h0, ~i[0], 2'b01});
      rd(rtc_pkg::IDX_SIGNAL_READBACK, {24'h0, rssi_lvl});
    end
    wr(rtc_pkg::IDX_SIGNAL_AVG_CONFIG, 8'h02);
    rssi_lvl <= 8'h10;
    wr(rtc_pkg::IDX_CHANNEL_CHECK, 8'h04);
    wr(rtc_pkg::IDX_COMMAND, rtc_pkg::CMD_CHANNEL_CHECK);
    waitsig(1, 5000);
    rssi_lvl <= 8'h80;
    rd(rtc_pkg::IDX_SIGNAL_READBACK, 32'h10);
    waitsig(1, 5000);
    near(c, 1276);
    rd(rtc_pkg::IDX_STATUS, 32'h8);
    waitsig(1, 5000);
    rd(rtc_pkg::IDX_SIGNAL_READBACK, 32'h80);
    wr(rtc_pkg::IDX_COMMAND, rtc_pkg::CMD_IDLE_READY);
    waitsig(1, 2000);
    chk(c, 2000);
    wr(rtc_pkg::IDX_CHANNEL_CHECK, 8'h02);
    wr(rtc_pkg::IDX_PACKET_OPTIONS, 8'h06);
    wr(rtc_pkg::IDX_COMMAND, rtc_pkg::CMD_RECEIVE);
    waitsig(0, 5000);
    near(c, 220);
    waitsig(1, 5000);
    near(c, 1280);
    model.send_frame(8'h5a, 3'h1, 1'b1, 8'h77, 1'b1);
    waitsig(3, 100);
    chk(ack_seq, 32'h5a);
    chk(quality_data, 32'h77);
    waitsig(2, 6000);
    near(c, 4000);
    model.send_done();
    rd(rtc_pkg::IDX_STATUS, 32'h1);
    rd(rtc_pkg::IDX_QUALITY_READBACK, 32'h77);
    wr(rtc_pkg::IDX_CHANNEL_CHECK, 8'h00);
    wr(rtc_pkg::IDX_COMMAND, rtc_pkg::CMD_RECEIVE);
    waitsig(0, 5000);
    model.send_frame(8'h01, 3'h1, 1'b1, 8'h20, 1'b0);
    waitsig(3, 100);
    chk(c, 100);
    model.send_frame(8'h02, rtc_pkg::FTYPE_BEACON, 1'b1, 8'h20, 1'b1);
    waitsig(3, 100);
    chk(c < 100, 1);
    waitsig(2, 300);
    chk(c, 300);
    rd(rtc_pkg::IDX_STATUS, 32'h1);
    wr(rtc_pkg::IDX_RADIO_MODE_SELECT, rtc_pkg::MODE_SERIAL_PORT);
    wr(rtc_pkg::IDX_COMMAND, rtc_pkg::CMD_RECEIVE);
    waitsig(0, 5000);
    model.send_frame(8'h03, 3'h1, 1'b0, 8'h20, 1'b1);
    waitsig(3, 100);
    chk({c[30:0], rx_enable}, {31'd100, 1'b1});
    wr(rtc_pkg::IDX_COMMAND, rtc_pkg::CMD_IDLE_READY);
    rd(rtc_pkg::IDX_STATUS, 32'h1);
    wr(rtc_pkg::IDX_RADIO_MODE_SELECT, rtc_pkg::MODE_PACKET);
    wr(rtc_pkg::IDX_RX_BUFFER_BEHAVIOR, 8'h08);
    model.send_done();
    waitsig(0, 5000);
    near(c, 220);
    model.send_frame(8'h04, 3'h1, 1'b0, 8'h20, 1'b1);
    waitsig(3, 100);
    repeat (3) @(posedge mclk);
    rd(rtc_pkg::IDX_STATUS, 32'h1);
    chk(n_sfd, 5);
    tally_and_finish();
  end
endmodule
